/* File: design/hwmc_top.sv */
/*
 mode sequencer with shared SPI/UART command front end, busy, status,
 interrupt routing and receive timeout.
 assumes radio status inputs are on ref_clk; host pins are asynchronous.
*/
`timescale 1ns/1ns
module hwmc_top #(
  parameter int CAL_CYCLES = 64,
  parameter int TICK_BASE  = 25
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic                  csUartClearToSendIn,
  input  wire logic                  sckIn,
  output      logic                  uartRequestToSendOut,
  output      logic                  uartRequestToSendOe,
  input  wire logic                  mosiRxIn,
  output      logic                  misoTxOut,
  output      logic                  misoTxOe,
  output      logic                  busy,
  output      logic [2:0]            multiPurposePin,
  input  wire logic                  wakeTimerEoc,
  input  wire logic                  memRetained,
  input  wire logic                  dcdcSel,
  input  wire logic                  pllLocked,
  input  wire logic                  rxReady,
  input  wire logic                  rxPacketDone,
  input  wire logic                  paRamped,
  input  wire logic                  txPacketSent,
  input  wire logic [31:0]           txFreqHz,
  output      logic [31:0]           pllFreqHz,
  output      hwmc_pkg::hwmc_power_t power,
  output      logic [3:0]            calStage,
  output      logic                  calReload
);
  import hwmc_pkg::*;

  localparam logic [15:0] CAL_LAST = 16'(CAL_CYCLES - 1);

  logic [1:0] rstSync_reg;
  logic [2:0] pinMeta_reg, pinSync_reg, pinLast_reg;
  logic       csRiseD_reg;
  wire        rstnInt = rstSync_reg[1];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rstSync_reg <= 2'b00;
    else rstSync_reg <= {rstSync_reg[0], 1'b1};
  end

  // two-stage sync of cs, sck, mosi
  always_ff @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      // idle levels: rx high, sck low, cs high
      pinMeta_reg <= 3'h5;
      pinSync_reg <= 3'h5;
      pinLast_reg <= 3'h5;
    end else begin
      pinMeta_reg <= {mosiRxIn, sckIn, csUartClearToSendIn};
      pinSync_reg <= pinMeta_reg;
      pinLast_reg <= pinSync_reg;
    end
  end

  wire cs       = pinSync_reg[0];
  wire mosi     = pinSync_reg[2];
  wire csFall   = pinLast_reg[0] & ~cs;
  wire csRise   = ~pinLast_reg[0] & cs;
  wire sckRise  = ~pinLast_reg[1] & pinSync_reg[1];
  wire sckFall  = pinLast_reg[1] & ~pinSync_reg[1];
  wire mosiFall = pinLast_reg[2] & ~mosi;

  hwmc_state_t state_reg, state_next, cmdMode;
  hwmc_power_t pw_next, power_reg;
  hwmc_ucfg_t  ucfg_reg;
  logic [1:0]  ifSel_reg, calStep_reg, rxTb_reg;
  logic [15:0] calCnt_reg, rxLeft_reg;
  logic [19:0] rxTick_reg;
  logic [7:0]  pIdx_reg, opc_reg, uLen_reg, irq_reg, spiSh_reg, misoSh_reg;
  logic [7:0]  par_reg [4];
  logic [7:0]  route_reg [3];
  logic [2:0]  spiBit_reg, cmdStat_reg, mp_reg;
  logic        reload_reg, cmdGo_reg, rxCont_reg;
  logic        urxAct_reg, urxErr_reg, utxAct_reg, utxPend_reg;
  logic [11:0] urxDiv_reg, utxDiv_reg, utxSh_reg;
  logic [3:0]  urxIdx_reg, utxLeft_reg, calStage_reg;
  logic [7:0]  urxSh_reg;
  logic [31:0] pllFreq_reg;

  wire inSleep = state_reg == S_SLEEP;
  wire inInit  = state_reg == S_INIT;
  wire inRc    = state_reg == S_RC;
  wire inSynth = state_reg == S_SYNTH;
  wire inRx    = state_reg == S_RX;
  wire inTx    = state_reg == S_TX;
  wire isUart  = ifSel_reg == IF_UART;

  // ---- SPI byte engine, MSB first, mode 0 ----
  wire       spiEn   = !isUart && !cs; // RULE_24
  wire       spiStb  = spiEn && sckRise && spiBit_reg == 3'h7;
  wire [7:0] spiByte = {spiSh_reg[6:0], mosi};
  wire [2:0] modeCode = inRc ? MC_RC : (state_reg == S_CRYSTAL_OSCILLATOR) ? MC_CRYSTAL_OSCILLATOR :
                        inSynth ? MC_SYNTH : inRx ? MC_RX : inTx ? MC_TX : MC_NONE;
  wire [7:0] statusByte = {modeCode, cmdStat_reg, 1'b0, busy};

  always_ff @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      spiBit_reg  <= 3'h0;
      spiSh_reg   <= 8'h00;
      misoSh_reg  <= 8'h00;
      csRiseD_reg <= 1'b0;
    end else begin
      csRiseD_reg <= csRise;
      if (cs) spiBit_reg <= 3'h0;
      else if (spiEn && sckRise) begin
        spiSh_reg  <= spiByte;
        spiBit_reg <= spiBit_reg + 3'h1;
      end
      // status out on every SPI byte
      if (csFall || (sckFall && spiBit_reg == 3'h0)) misoSh_reg <= statusByte; // RULE_14
      else if (sckFall) misoSh_reg <= {misoSh_reg[6:0], 1'b0};
    end
  end

  // ---- UART receive ----
  wire        uEn    = ifSel_reg != IF_SPI;
  wire        parOn  = ucfg_reg.parity != PAR_NONE;
  wire [11:0] bdiv   = baudDiv(ucfg_reg.baud); // RULE_05
  wire [3:0]  uLast  = 4'h9 + {3'h0, parOn} + {3'h0, ucfg_reg.twoStop}; // RULE_06
  wire        uTick  = urxAct_reg && urxDiv_reg == 12'h000;
  wire        uIsPar = parOn && urxIdx_reg == 4'h9;
  wire        parExp = (ucfg_reg.parity == PAR_ODD) ? ~^urxSh_reg : ^urxSh_reg;
  wire        uStop  = urxIdx_reg > 4'h8 && !uIsPar;
  wire        uBad   = uTick && ((uIsPar && mosi != parExp) || (uStop && !mosi)); // RULE_06
  wire        uDone  = uTick && urxIdx_reg == uLast;
  wire        urxGood = uDone && uEn && !urxErr_reg && !uBad;
  wire        urxFail = uDone && uEn && (urxErr_reg || uBad);

  always_ff @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      urxAct_reg <= 1'b0;
      urxErr_reg <= 1'b0;
      urxDiv_reg <= 12'h000;
      urxIdx_reg <= 4'h0;
      urxSh_reg  <= 8'h00;
    end else if (!urxAct_reg) begin
      if (uEn && mosiFall) begin
        urxAct_reg <= 1'b1;
        urxErr_reg <= 1'b0;
        urxDiv_reg <= {1'b0, bdiv[11:1]};
        urxIdx_reg <= 4'h0;
      end
    end else if (uTick) begin
      urxDiv_reg <= bdiv - 12'h001;
      urxIdx_reg <= urxIdx_reg + 4'h1;
      if (uBad) urxErr_reg <= 1'b1;
      // lsb arrives first
      if (urxIdx_reg != 4'h0 && urxIdx_reg < 4'h9) urxSh_reg <= {mosi, urxSh_reg[7:1]}; // RULE_07
      if ((urxIdx_reg == 4'h0 && mosi) || uDone) urxAct_reg <= 1'b0;
    end else urxDiv_reg <= urxDiv_reg - 12'h001;
  end

  // ---- command parser ----
  wire       byteUart = urxGood && !spiStb;
  wire       byteStb  = spiStb || urxGood;
  wire [7:0] byteVal  = spiStb ? spiByte : urxSh_reg;
  wire [7:0] pOff     = byteUart ? 8'h02 : 8'h01;
  wire [7:0] parIdx   = pIdx_reg - pOff;
  wire       spiEnd   = csRiseD_reg && !isUart && pIdx_reg != 8'h00;
  wire       uartEnd  = byteUart && (pIdx_reg == 8'h01 ? byteVal == 8'h00 :
                        pIdx_reg > 8'h01 && pIdx_reg - 8'h01 == uLen_reg); // RULE_09
  wire       cmdEnd   = spiEnd || uartEnd;
  wire       opKnown  = opc_reg inside {OP_SLEEP, OP_STANDBY, OP_SYNTH, OP_RX, OP_TX,
                                        OP_ROUTE, OP_CLRIRQ, OP_STATUS, OP_UCFG};
  wire       sleepBad = opc_reg == OP_SLEEP && !inRc;
  wire       opDo     = cmdGo_reg && opKnown;

  always_ff @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      pIdx_reg  <= 8'h00;
      opc_reg   <= 8'h00;
      uLen_reg  <= 8'h00;
      cmdGo_reg <= 1'b0;
      ifSel_reg <= IF_NONE;
      for (int i = 0; i < 4; i++) par_reg[i] <= 8'h00;
    end else begin
      cmdGo_reg <= cmdEnd && !inSleep && !inInit;
      if (byteStb && pIdx_reg == 8'h00) opc_reg <= byteVal;
      if (byteUart && pIdx_reg == 8'h01) uLen_reg <= byteVal;
      if (byteStb && pIdx_reg >= pOff && parIdx < 8'h04) par_reg[parIdx[1:0]] <= byteVal;
      // further bytes open the next command
      if (cmdEnd) pIdx_reg <= 8'h00; // RULE_09
      else if (byteStb && pIdx_reg != 8'hff) pIdx_reg <= pIdx_reg + 8'h01;
      if (ifSel_reg == IF_NONE && spiEnd) ifSel_reg <= IF_SPI; // RULE_24
      else if (ifSel_reg == IF_NONE && urxGood) ifSel_reg <= IF_UART; // RULE_24
    end
  end

  // ---- mode sequencer ----
  wire calDone = inInit && calCnt_reg == CAL_LAST &&
                 (reload_reg || calStep_reg == CAL_LAST_STEP); // RULE_04 RULE_16
  wire [19:0] tickLen  = 20'(TICK_BASE) << {rxTb_reg, 1'b0};
  wire        tickWrap = rxTick_reg == tickLen - 20'h00001;
  wire        rxTmo    = inRx && rxLeft_reg == 16'h0001 && tickWrap; // RULE_21
  wire        rxDoneEv = inRx && rxPacketDone;
  wire        txDoneEv = inTx && txPacketSent;
  wire        rxLoad   = cmdGo_reg && opc_reg == OP_RX;

  assign cmdMode = !cmdGo_reg ? state_reg :
                   (opc_reg == OP_SLEEP) ? (inRc ? S_SLEEP : state_reg) : // RULE_17
                   (opc_reg == OP_STANDBY) ? (par_reg[0][0] ? S_CRYSTAL_OSCILLATOR : S_RC) : // RULE_18
                   (opc_reg == OP_SYNTH) ? S_SYNTH :
                   (opc_reg == OP_RX) ? S_RX :
                   (opc_reg == OP_TX) ? S_TX : state_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_SLEEP: if (csFall || wakeTimerEoc) state_next = S_INIT; // RULE_01 RULE_17
      S_INIT: if (calDone) state_next = S_RC; // RULE_04
      S_RX: begin
        if (cmdGo_reg) state_next = cmdMode;
        else if (rxTmo || (rxDoneEv && !rxCont_reg)) state_next = S_RC; // RULE_20 RULE_21
      end
      S_TX: begin
        if (cmdGo_reg) state_next = cmdMode;
        else if (txDoneEv) state_next = S_RC; // RULE_22
      end
      default: state_next = cmdMode;
    endcase
  end

  // oscillators, regulators, radio blocks per mode
  always_comb begin
    pw_next = '0;
    case (state_next)
      S_SLEEP: pw_next.rcSlowOscillator = 1'b1;
      S_INIT: pw_next = '{rcFastOscillator: 1'b1, crystalOscillator: 1'b1,
                          ldo: 1'b1, default: 1'b0}; // RULE_01
      S_RC: pw_next = '{rcFastOscillator: 1'b1, ldo: 1'b1, default: 1'b0}; // RULE_15
      S_CRYSTAL_OSCILLATOR: pw_next = '{rcFastOscillator: 1'b1, crystalOscillator: 1'b1, ldo: !dcdcSel,
                          dcdc: dcdcSel, default: 1'b0}; // RULE_18
      S_SYNTH: pw_next = '{crystalOscillator: 1'b1, ldo: 1'b1, pll: 1'b1, default: 1'b0};
      S_RX: pw_next = '{crystalOscillator: 1'b1, ldo: 1'b1, pll: 1'b1, rxChain: 1'b1,
                        default: 1'b0}; // RULE_15
      S_TX: pw_next = '{crystalOscillator: 1'b1, ldo: 1'b1, pll: 1'b1, txChain: 1'b1,
                        default: 1'b0}; // RULE_22
      default: pw_next = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      state_reg  <= S_INIT;
      reload_reg <= 1'b0;
      calCnt_reg <= CAL_RST;
      calStep_reg <= 2'h0;
      power_reg  <= '0;
      pllFreq_reg <= 32'h00000000;
    end else begin
      state_reg <= state_next;
      power_reg <= pw_next;
      // synth tunes to tx frequency, rx sits one IF below
      pllFreq_reg <= (state_next == S_RX) ? txFreqHz - 32'(IF_OFFSET_HZ) : txFreqHz; // RULE_19
      if (inSleep) reload_reg <= memRetained; // RULE_16
      if (!inInit || calDone) begin
        calCnt_reg  <= CAL_RST;
        calStep_reg <= 2'h0;
      end else if (calCnt_reg == CAL_LAST) begin
        calCnt_reg  <= CAL_RST;
        calStep_reg <= calStep_reg + 2'h1; // RULE_04
      end else calCnt_reg <= calCnt_reg + 16'h0001;
    end
  end

  // receive timeout and command side effects
  wire [7:0] irqSet = {2'h0, urxFail, utxAct_reg && utxDiv_reg == 12'h000 &&
                       utxLeft_reg == 4'h0, urxGood, rxTmo, rxDoneEv, txDoneEv}; // RULE_06
  wire [7:0] irqClr = (opDo && opc_reg == OP_CLRIRQ) ? par_reg[0] : 8'h00;
  wire [2:0] cmdStatNext = txDoneEv ? ST_TXDONE : rxDoneEv ? ST_DATA : rxTmo ? ST_TMO :
                           !cmdGo_reg ? cmdStat_reg : !opKnown ? ST_ERR :
                           sleepBad ? ST_FAIL : ST_OK;
  wire [2:0] mpRaw;

  for (genvar i = 0; i < 3; i++) begin : g_route
    assign mpRaw[i] = |(irq_reg & route_reg[i]); // RULE_11
  end

  always_ff @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      rxTb_reg    <= 2'h0;
      rxCont_reg  <= 1'b0;
      rxLeft_reg  <= 16'h0000;
      rxTick_reg  <= 20'h00000;
      irq_reg     <= 8'h00;
      cmdStat_reg <= 3'h0;
      ucfg_reg    <= UCFG_RST; // RULE_07
      mp_reg      <= 3'h0;
      for (int i = 0; i < 3; i++) route_reg[i] <= 8'h00;
    end else begin
      // new events win over a clear in the same cycle
      irq_reg     <= (irq_reg & ~irqClr) | irqSet; // RULE_13
      cmdStat_reg <= cmdStatNext;
      mp_reg      <= mpRaw;
      if (opDo && opc_reg == OP_UCFG) ucfg_reg <= par_reg[0][5:0]; // RULE_06
      if (opDo && opc_reg == OP_ROUTE) begin
        for (int i = 0; i < 3; i++) route_reg[i] <= par_reg[i]; // RULE_11
      end
      if (rxLoad) begin
        rxTb_reg   <= par_reg[0][1:0]; // RULE_21
        rxCont_reg <= par_reg[0][2]; // RULE_20
        rxLeft_reg <= {par_reg[1], par_reg[2]};
        rxTick_reg <= 20'h00000;
      end else if (inRx && rxLeft_reg != 16'h0000) begin
        if (tickWrap) begin
          rxTick_reg <= 20'h00000;
          rxLeft_reg <= rxLeft_reg - 16'h0001;
        end else rxTick_reg <= rxTick_reg + 20'h00001;
      end
    end
  end

  // ---- UART transmit of status ----
  wire        txPar   = (ucfg_reg.parity == PAR_ODD) ? ~^statusByte : ^statusByte;
  wire [11:0] txFrame = parOn ? {2'b11, txPar, statusByte, 1'b0} : {3'b111, statusByte, 1'b0};
  wire        txStart = utxPend_reg && !utxAct_reg && !cs; // RULE_08
  wire        txQuery = opDo && opc_reg == OP_STATUS && isUart; // RULE_14

  always_ff @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      utxAct_reg  <= 1'b0;
      utxPend_reg <= 1'b0;
      utxDiv_reg  <= 12'h000;
      utxSh_reg   <= 12'hfff;
      utxLeft_reg <= 4'h0;
    end else begin
      utxPend_reg <= (utxPend_reg && !txStart) || txQuery;
      if (txStart) begin
        utxAct_reg  <= 1'b1;
        utxSh_reg   <= txFrame;
        utxDiv_reg  <= bdiv - 12'h001;
        utxLeft_reg <= uLast;
      end else if (utxAct_reg && utxDiv_reg == 12'h000) begin
        utxDiv_reg <= bdiv - 12'h001;
        utxSh_reg  <= {1'b1, utxSh_reg[11:1]};
        if (utxLeft_reg == 4'h0) utxAct_reg <= 1'b0;
        else utxLeft_reg <= utxLeft_reg - 4'h1;
      end else if (utxAct_reg) utxDiv_reg <= utxDiv_reg - 12'h001;
    end
  end

  // ---- pins ----
  wire rdyHard = !(inSleep || inInit || cmdGo_reg);
  assign busy = inSleep || inInit || cmdGo_reg || pIdx_reg != 8'h00 ||
                (inSynth && !pllLocked) || (inRx && !rxReady) ||
                (inTx && !paRamped); // RULE_03 RULE_12 RULE_19
  assign uartRequestToSendOut = !rdyHard; // RULE_10
  assign uartRequestToSendOe  = isUart; // RULE_10
  assign misoTxOut = isUart ? (!utxAct_reg || utxSh_reg[0]) : misoSh_reg[7]; // RULE_10
  assign misoTxOe  = isUart || spiEn; // RULE_10
  assign multiPurposePin = mp_reg;
  assign pllFreqHz = pllFreq_reg;
  assign power     = power_reg;
  assign calReload = inInit && reload_reg;
  assign calStage  = calStage_reg;

  always_ff @(posedge ref_clk or negedge rstnInt) begin
    if (!rstnInt) calStage_reg <= 4'h0;
    else calStage_reg <= (inInit && !reload_reg) ? 4'h1 << calStep_reg : 4'h0; // RULE_04
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstnInt);

  busyAsleep_a: assert property ((inSleep || inInit) |-> busy) // RULE_03
    else $error("busy low in sleep or init");
  wakeCs_a: assert property (inSleep && csFall |=> inInit ##1 power_reg.ldo) // RULE_01
    else $error("no wake on chip-select fall");
  calOrder_a: assert property (inInit && !reload_reg && calCnt_reg == CAL_LAST &&
      calStep_reg != CAL_LAST_STEP |=> calStep_reg == $past(calStep_reg) + 2'h1) // RULE_04
    else $error("calibration step order broken");
  calEnd_a: assert property (calDone |=> inRc) // RULE_16
    else $error("init did not end in RC standby");
  sleepFrom_a: assert property ($rose(inSleep) |-> $past(state_reg) == S_RC) // RULE_17
    else $error("sleep entered from wrong mode");
  synthBusy_a: assert property (inSynth && !pllLocked |-> busy) // RULE_19
    else $error("busy low before lock");
  rxSingle_a: assert property (rxDoneEv && !rxCont_reg && !cmdGo_reg |=> inRc) // RULE_20
    else $error("single receive did not return");
  rxTmo_a: assert property (rxTmo && !cmdGo_reg |=> inRc && irq_reg[IRQ_TMO]) // RULE_21
    else $error("receive timeout ignored");
  txBack_a: assert property (txDoneEv && !cmdGo_reg |=> inRc && cmdStat_reg == ST_TXDONE) // RULE_22
    else $error("transmit did not return");
  irqWins_a: assert property (irqSet[IRQ_TXDONE] |=> irq_reg[IRQ_TXDONE]) // RULE_13
    else $error("interrupt event lost");
  misoOff_a: assert property (!isUart && cs |-> !misoTxOe) // RULE_10
    else $error("miso driven while deselected");
  ifLock_a: assert property (ifSel_reg != IF_NONE |=> $stable(ifSel_reg)) // RULE_24
    else $error("interface choice changed");

  wakeSeen_c: cover property (inSleep && csFall ##[1:300] inRc);
  txRound_c: cover property (inTx ##[1:300] inRc);
  uartPick_c: cover property (ifSel_reg == IF_NONE ##1 isUart);
  rxTimeout_c: cover property (rxTmo);
endmodule // hwmc_top

/* File: shared/hwmc_pkg.sv */
/*
 host wake and mode control: shared constants, types and helpers.
 assumes a 25 MHz core clock and a host on the shared SPI/UART pins.
*/
// Contract
// RULE_01 - chip-select falling edge wakes from sleep, powers regulators, starts init
// RULE_02 - host waits 125 us after chip-select low before first clock edge
// RULE_03 - busy high in sleep and init, low once in RC standby
// RULE_04 - power-up calibrates fast RC, slow RC, modulation path, ADC, then RC standby
// RULE_05 - UART offers seven baud rates from 921.6 k down to 9.6 k
// RULE_06 - UART 8-bit words, parity, one or two stops, flow control, events
// RULE_07 - UART defaults 115.2 k, one stop, even parity, CTS, LSB first
// RULE_08 - host drives clear-to-send low to start UART traffic
// RULE_09 - UART command carries length; run when complete, extra bytes start anew
// RULE_10 - four host pins shared between SPI and UART functions
// RULE_11 - three multi-purpose pins, each routable to any interrupt
// RULE_12 - busy always an output, low when a new command may come
// RULE_13 - host reads interrupt cause; clear command clears interrupt bits; no command reads irq_reg, only the routed pins show it
// RULE_14 - SPI returns status every transaction; UART only on status query
// RULE_15 - six modes, each enabling only its own oscillators and blocks
// RULE_16 - wake with retained memory reloads calibration instead of full run
// RULE_17 - sleep entered only from RC standby; left by chip-select or timer
// RULE_18 - standby command picks RC or crystal clock; crystal with DC-DC powers it
// RULE_19 - synth mode tunes to transmit frequency; busy drops at lock; IF offset
// RULE_20 - continuous receive stays; single receive returns to RC standby
// RULE_21 - receive timeout from timebase and ticks returns to RC standby
// RULE_22 - transmit after PA ramp, return to RC standby when sent
// RULE_23 - host issues commands only while busy is low
// RULE_24 - both interfaces live until one sees a valid transaction
package hwmc_pkg;
  localparam int CLK_HZ       = 25_000_000;
  localparam int IF_OFFSET_HZ = 1_300_000;
  localparam logic [15:0] CAL_RST = 16'h0000;

  localparam logic [1:0] IF_NONE = 2'h0, IF_SPI = 2'h1, IF_UART = 2'h2;
  localparam logic [1:0] PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2;
  localparam logic [1:0] CAL_LAST_STEP = 2'h3;

  // opcode values are arbitrary
  localparam logic [7:0] OP_SLEEP = 8'h10, OP_STANDBY = 8'h11, OP_SYNTH = 8'h12;
  localparam logic [7:0] OP_RX = 8'h13, OP_TX = 8'h14, OP_ROUTE = 8'h20;
  localparam logic [7:0] OP_CLRIRQ = 8'h21, OP_STATUS = 8'h22, OP_UCFG = 8'h23;

  localparam int IRQ_TXDONE = 0, IRQ_RXDONE = 1, IRQ_TMO = 2;
  localparam int IRQ_URXFULL = 3, IRQ_UTXEMPTY = 4, IRQ_UERR = 5;

  localparam logic [2:0] ST_OK = 3'h1, ST_DATA = 3'h2, ST_TMO = 3'h3;
  localparam logic [2:0] ST_ERR = 3'h4, ST_FAIL = 3'h5, ST_TXDONE = 3'h6;
  localparam logic [2:0] MC_RC = 3'h2, MC_CRYSTAL_OSCILLATOR = 3'h3, MC_SYNTH = 3'h4;
  localparam logic [2:0] MC_RX = 3'h5, MC_TX = 3'h6, MC_NONE = 3'h0;

  typedef enum logic [6:0] {
    S_SLEEP = 7'b0000001, S_INIT = 7'b0000010, S_RC = 7'b0000100,
    S_CRYSTAL_OSCILLATOR = 7'b0001000, S_SYNTH = 7'b0010000, S_RX = 7'b0100000,
    S_TX = 7'b1000000
  } hwmc_state_t;

  typedef struct packed {
    logic rcFastOscillator;
    logic rcSlowOscillator;
    logic crystalOscillator;
    logic ldo;
    logic dcdc;
    logic pll;
    logic rxChain;
    logic txChain;
  } hwmc_power_t;

  typedef struct packed {
    logic       twoStop;
    logic [1:0] parity;
    logic [2:0] baud;
  } hwmc_ucfg_t;

  localparam hwmc_ucfg_t UCFG_RST = '{twoStop: 1'b0, parity: PAR_EVEN, baud: 3'h2};

  function automatic logic [11:0] baudDiv(input logic [2:0] s);
    case (s)
      3'h0:    baudDiv = 12'(CLK_HZ / 921_600);
      3'h1:    baudDiv = 12'(CLK_HZ / 460_600);
      3'h3:    baudDiv = 12'(CLK_HZ / 57_600);
      3'h4:    baudDiv = 12'(CLK_HZ / 38_400);
      3'h5:    baudDiv = 12'(CLK_HZ / 19_200);
      3'h6:    baudDiv = 12'(CLK_HZ / 9_600);
      default: baudDiv = 12'(CLK_HZ / 115_200);
    endcase
  endfunction
endpackage

/* File: bench/hwmc_host.sv */
/*
 host model: SPI master and UART host on the shared pins of the mode controller.
 assumes ref_clk is the core clock; sck runs at 8 core cycles a period.
*/
`timescale 1ns/1ns
module hwmc_host (
  input  wire logic ref_clk,
  input  wire logic misoTxOut,
  input  wire logic busy,
  output logic      csN,
  output logic      sck,
  output logic      mosi
);
  localparam int BIT_CYC = 217; // 115.2 kb/s in 40 ns cycles
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // four bytes msb first; status taken from the first byte
  task automatic xfer(input logic [31:0] d, output logic [7:0] st);
    int i;
    for (i = 0; i < 4000 && busy !== 1'b0; i++) hold(1);
    csN <= 1'b0;
    hold(4);
    for (i = 31; i >= 0; i--) begin
      mosi <= d[i];
      hold(4);
      sck <= 1'b1;
      if (i > 23) st[i-24] = misoTxOut;
      hold(4);
      sck <= 1'b0;
    end
    hold(4);
    csN <= 1'b1;
    mosi <= ~mosi;
    hold(8);
  endtask
  // chip-select alone, no clock edge during the wake-up time
  task automatic wake();
    csN <= 1'b0;
    hold(3125);
    csN <= 1'b1;
    hold(8);
  endtask
  // uart idle line, clear-to-send low
  task automatic uartMode();
    csN  <= 1'b0;
    mosi <= 1'b1;
  endtask
  // lsb first, even parity, one stop
  task automatic uartByte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int k = 0; k < 11; k++) begin
      mosi <= f[k];
      hold(BIT_CYC);
    end
  endtask
  // waits for an idle line, then a start bit; samples mid-bit
  task automatic uartRead(output logic [7:0] b);
    int k;
    for (k = 0; k < 20000 && misoTxOut !== 1'b1; k++) hold(1);
    for (k = 0; k < 20000 && misoTxOut !== 1'b0; k++) hold(1);
    hold(BIT_CYC / 2);
    for (k = 0; k < 8; k++) begin
      hold(BIT_CYC);
      b[k] = misoTxOut;
    end
  endtask
endmodule // hwmc_host

/* File: bench/tb_hwmc_top.sv */
/*
 testbench: SPI command sequences and a UART status query against the mode controller.
 assumes hwmc_host drives the host pins and the radio inputs are levels.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_hwmc_top;
  import hwmc_pkg::*;
  logic        ref_clk = 0, rstn = 0, memRetained = 0, dcdcSel = 1;
  logic        pllLocked = 0, rxReady = 0, paRamped = 0, txPacketSent = 0;
  logic        rxDone = 0, wakeEoc = 0;
  logic [31:0] txFreqHz = 32'h8f0d1800;
  wire         csN, sck, mosi, miso, busy, calReload;
  wire         rtsOut, rtsOe, misoOe;
  wire  [3:0]  calStage_w;
  wire  [2:0]  pins;
  wire  [31:0] pllFreqHz;
  hwmc_power_t power;
  int          n_errors = 0, n_tests = 0, i;
  logic [7:0]  st;
  logic [3:0]  stg = 0;
  logic        rel = 0;
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) rel <= rel | (calReload === 1'b1);
  hwmc_host hwmc_host_i (.ref_clk(ref_clk), .misoTxOut(miso), .busy(busy),
    .csN(csN), .sck(sck), .mosi(mosi));
  hwmc_top #(.CAL_CYCLES(4), .TICK_BASE(2)) hwmc_top_i (.ref_clk(ref_clk),
    .rstn(rstn), .csUartClearToSendIn(csN), .sckIn(sck), .uartRequestToSendOut(rtsOut),
    .uartRequestToSendOe(rtsOe), .mosiRxIn(mosi), .misoTxOut(miso), .misoTxOe(misoOe),
    .busy(busy), .multiPurposePin(pins), .wakeTimerEoc(wakeEoc),
    .memRetained(memRetained), .dcdcSel(dcdcSel), .pllLocked(pllLocked),
    .rxReady(rxReady), .rxPacketDone(rxDone), .paRamped(paRamped),
    .txPacketSent(txPacketSent), .txFreqHz(txFreqHz), .pllFreqHz(pllFreqHz),
    .power(power), .calStage(calStage_w), .calReload(calReload));
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic waitIdle();
    for (i = 0; i < 4000 && busy !== 1'b0; i++) begin
      // settled values, away from the launching edge
      @(negedge ref_clk);
      stg = stg | calStage_w;
    end
  endtask
  task automatic cmd(input logic [31:0] d);
    hwmc_host_i.xfer(d, st);
    waitIdle();
  endtask
  initial begin
    #1_500_000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    `CHK(busy, 1'b1);
    rstn <= 1'b1;
    waitIdle();
    `CHK(stg, 4'hf);
    `CHK(power.rcFastOscillator, 1'b1);
    `CHK(power.txChain, 1'b0);
    cmd({OP_STATUS, 24'h0});
    `CHK(st[7:5], MC_RC);
    `CHK(rtsOe, 1'b0);
    `CHK(misoOe, 1'b0);
    cmd({OP_STANDBY, 8'h01, 16'h0});
    `CHK(power.crystalOscillator, 1'b1);
    `CHK(power.dcdc, 1'b1);
    $display("startup and standby done");
    hwmc_host_i.xfer({OP_SYNTH, 24'h0}, st);
    repeat (20) @(posedge ref_clk);
    `CHK(busy, 1'b1);
    pllLocked <= 1'b1;
    waitIdle();
    `CHK(pllFreqHz, txFreqHz);
    cmd({OP_SLEEP, 24'h0});
    cmd({OP_STATUS, 24'h0});
    `CHK(st[4:2], ST_FAIL);
    `CHK(st[7:5], MC_SYNTH);
    cmd({OP_STANDBY, 24'h0});
    memRetained <= 1'b1;
    hwmc_host_i.xfer({OP_SLEEP, 24'h0}, st);
    repeat (50) @(posedge ref_clk);
    `CHK(busy, 1'b1);
    hwmc_host_i.wake();
    waitIdle();
    `CHK(rel, 1'b1);
    `CHK(busy, 1'b0);
    $display("synth and sleep done");
    cmd({OP_ROUTE, 8'h04, 8'h01, 8'h00});
    rxReady <= 1'b1;
    hwmc_host_i.xfer({OP_RX, 8'h00, 16'h0100}, st);
    `CHK(pllFreqHz, txFreqHz - 32'(IF_OFFSET_HZ));
    repeat (700) @(posedge ref_clk);
    `CHK(pins[0], 1'b1);
    cmd({OP_STATUS, 24'h0});
    `CHK(st[7:5], MC_RC);
    cmd({OP_CLRIRQ, 8'h04, 16'h0});
    `CHK(pins[0], 1'b0);
    cmd({OP_RX, 8'h04, 16'h0});
    rxDone <= 1'b1;
    @(posedge ref_clk);
    rxDone <= 1'b0;
    cmd({OP_STATUS, 24'h0});
    `CHK(st[7:5], MC_RX);
    `CHK(st[4:2], ST_DATA);
    cmd({OP_RX, 24'h0});
    rxDone <= 1'b1;
    @(posedge ref_clk);
    rxDone <= 1'b0;
    repeat (3) @(posedge ref_clk);
    `CHK(power.rxChain, 1'b0);
    $display("receive timeout done");
    paRamped <= 1'b1;
    cmd({OP_TX, 24'h0});
    txPacketSent <= 1'b1;
    @(posedge ref_clk);
    txPacketSent <= 1'b0;
    repeat (5) @(posedge ref_clk);
    `CHK(pins[1], 1'b1);
    cmd({8'h7e, 24'h0});
    cmd({OP_STATUS, 24'h0});
    `CHK(st[7:5], MC_RC);
    `CHK(st[4:2], ST_ERR);
    $display("transmit and refusal done");
    hwmc_host_i.xfer({OP_SLEEP, 24'h0}, st);
    `CHK(power.rcSlowOscillator, 1'b1);
    wakeEoc <= 1'b1;
    @(posedge ref_clk);
    wakeEoc <= 1'b0;
    waitIdle();
    `CHK(power.ldo, 1'b1);
    $display("timer wake done");
    @(posedge ref_clk);
    hwmc_host_i.uartMode();
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    waitIdle();
    @(posedge ref_clk);
    fork
      hwmc_host_i.uartRead(st);
      begin
        hwmc_host_i.uartByte(OP_STATUS);
        hwmc_host_i.uartByte(8'h00);
      end
    join
    `CHK(st[7:5], MC_RC);
    `CHK(st[4:2], ST_OK);
    `CHK(rtsOe, 1'b1);
    `CHK(rtsOut, 1'b0);
    $display("uart status done");
    conclude();
  end
endmodule // tb_hwmc_top
